/* File: verilog/scmr_pkg.sv */
// package: constants and types for the serial configuration memory reader
package scmr_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned SCMR_MAX_BITS  = 4194304;
   localparam int unsigned SCMR_ADDR_W    = 22;
   localparam int unsigned SCMR_BYTE_W    = 8;
   localparam int unsigned SCMR_BITCNT_W  = 3;
   localparam int unsigned SCMR_WORD_W    = SCMR_ADDR_W - SCMR_BITCNT_W;
   localparam int unsigned SCMR_WORDS     = SCMR_MAX_BITS / SCMR_BYTE_W;
   localparam logic [SCMR_ADDR_W-1:0] SCMR_ADDR_RST = 22'h00_0000;
   localparam logic [SCMR_BITCNT_W-1:0] SCMR_BIT_RST = 3'h0;
   localparam logic [SCMR_BITCNT_W-1:0] SCMR_BIT_LAST = 3'h7;
   localparam logic [SCMR_ADDR_W-1:0] SCMR_ADDR_ONE = 22'h00_0001;
   localparam logic [SCMR_ADDR_W-1:0] SCMR_ADDR_CAP_DEF = 22'h3F_FFFF;

   typedef enum logic [1:0]
   {
      SCMR_RESET,
      SCMR_STANDBY,
      SCMR_READ,
      SCMR_PROGRAM
   } scmr_state_type;

   typedef struct packed
   {
      logic data_out;
      logic data_oe;
   } scmr_pin_type;
endpackage

/* File: verilog/scmr_reader.sv */
// module: serial configuration memory read side
module scmr_reader
   import scmr_pkg::*;
#(
   parameter logic [SCMR_ADDR_W-1:0] LAST_ADDR = SCMR_ADDR_CAP_DEF
)
(
   input  wire logic                   CLK_SYS,
   input  wire logic                   RESETN,
   input  wire logic                   CLK_IN,
   input  wire logic                   CE_N,
   input  wire logic                   RESET_OE,
   input  wire logic                   SERIAL_PROGRAM_SELECT,
   input  wire logic                   RESET_POLARITY_HIGH,
   input  wire logic                   DATA_IN,
   input  wire logic                   LOAD_WE,
   input  wire logic [SCMR_WORD_W-1:0] LOAD_ADDR,
   input  wire logic [SCMR_BYTE_W-1:0] LOAD_DATA,
   output logic                        DATA_OUT,
   output logic                        DATA_OE,
   output logic                        STANDBY,
   output logic                        PROGRAM_MODE,
   output logic [SCMR_ADDR_W-1:0]      ADDRESS
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic       clk_q;

   // reset to idle pin levels so no false mode or edge follows reset
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sync_a <= 4'hA;
         sync_b <= 4'hA;
         clk_q  <= 1'b0;
      end
      else
      begin
         sync_a <= {SERIAL_PROGRAM_SELECT, RESET_OE, CE_N, CLK_IN};
         sync_b <= sync_a;
         clk_q  <= sync_b[0];
      end
   end

   logic clk_rise;
   logic ce_n_s;
   logic roe_s;
   logic sel_s;
   logic at_reset;
   logic run;

   assign clk_rise = sync_b[0] & ~clk_q;
   assign ce_n_s   = sync_b[1];
   assign roe_s    = sync_b[2];
   assign sel_s    = sync_b[3];
   // reset level follows programmed polarity
   assign at_reset = RESET_POLARITY_HIGH ? roe_s : ~roe_s;
   assign run      = sel_s & ~at_reset & ~ce_n_s;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [SCMR_BYTE_W-1:0] mem [SCMR_WORDS];
   logic [SCMR_BYTE_W-1:0] word_q;

   // contents arrive over the programming path only
   always_ff @(posedge CLK_SYS)
   begin
      if (LOAD_WE && !sel_s)
      begin
         mem[LOAD_ADDR] <= LOAD_DATA;
      end
      word_q <= mem[ADDRESS[SCMR_ADDR_W-1:SCMR_BITCNT_W]];
   end

   // ----------------------------------------------------------------
   // counters and pin control
   // ----------------------------------------------------------------
   scmr_state_type         state;
   scmr_state_type         next_state;
   logic [SCMR_ADDR_W-1:0] next_address;
   scmr_pin_type           next_pin;
   logic                   next_standby;
   logic                   unused_in;

   assign unused_in = DATA_IN;

   always_comb
   begin
      next_address = ADDRESS;
      next_state   = state;
      next_pin     = '0;
      next_standby = 1'b0;
      if (!sel_s)
      begin
         // chip enable has no say here
         next_state = SCMR_PROGRAM;
      end
      else if (at_reset)
      begin
         next_state   = SCMR_RESET;
         next_address = SCMR_ADDR_RST;
      end
      else if (ce_n_s)
      begin
         next_state   = SCMR_STANDBY;
         next_standby = 1'b1;
      end
      else
      begin
         next_state        = SCMR_READ;
         next_pin.data_oe  = 1'b1;
         next_pin.data_out = word_q[ADDRESS[SCMR_BITCNT_W-1:0]];
         if (run && clk_rise && ADDRESS != LAST_ADDR)
         begin
            next_address = ADDRESS + SCMR_ADDR_ONE;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state        <= SCMR_RESET;
         ADDRESS      <= SCMR_ADDR_RST;
         DATA_OUT     <= 1'b0;
         DATA_OE      <= 1'b0;
         STANDBY      <= 1'b0;
         PROGRAM_MODE <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         ADDRESS      <= next_address;
         DATA_OUT     <= next_pin.data_out;
         DATA_OE      <= next_pin.data_oe;
         STANDBY      <= next_standby;
         PROGRAM_MODE <= (next_state == SCMR_PROGRAM);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_reset_seen;
      sel_s && at_reset;
   endsequence

   property p_clear;
      @(posedge CLK_SYS) disable iff (!RESETN)
      s_reset_seen |=> ADDRESS == SCMR_ADDR_RST && !DATA_OE;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");

   property p_float;
      @(posedge CLK_SYS) disable iff (!RESETN)
      at_reset |=> !DATA_OE;
   endproperty
   a_float: assert property (p_float)
      else $error("data driven at reset");

   property p_halt;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (sel_s && !at_reset && ce_n_s) |=> $stable(ADDRESS) && !DATA_OE;
   endproperty
   a_halt: assert property (p_halt)
      else $error("counter moved in standby");

   property p_enable;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (sel_s && !at_reset && !ce_n_s) |=> DATA_OE;
   endproperty
   a_enable: assert property (p_enable)
      else $error("driver not enabled");

   property p_drive;
      @(posedge CLK_SYS) disable iff (!RESETN)
      DATA_OE |-> $past(run);
   endproperty
   a_drive: assert property (p_drive)
      else $error("driven without enable");

   property p_step;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (run && clk_rise && ADDRESS != LAST_ADDR)
         |=> ADDRESS == $past(ADDRESS) + SCMR_ADDR_ONE;
   endproperty
   a_step: assert property (p_step) else $error("address did not step");

   property p_nostep;
      @(posedge CLK_SYS) disable iff (!RESETN)
      !(run && clk_rise) && !at_reset |=> $stable(ADDRESS);
   endproperty
   a_nostep: assert property (p_nostep) else $error("address stepped");

   property p_prog;
      @(posedge CLK_SYS) disable iff (!RESETN)
      !sel_s |=> PROGRAM_MODE && !DATA_OE && !STANDBY;
   endproperty
   a_prog: assert property (p_prog) else $error("program mode wrong");

   sequence s_standby_seen;
      sel_s && !at_reset && ce_n_s;
   endsequence

   property p_standby;
      @(posedge CLK_SYS) disable iff (!RESETN)
      s_standby_seen |=> STANDBY && !PROGRAM_MODE;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby not entered");

   property p_hold_last;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (run && clk_rise && ADDRESS == LAST_ADDR) |=> ADDRESS == LAST_ADDR;
   endproperty
   a_hold_last: assert property (p_hold_last)
      else $error("address passed the last bit");
endmodule

/* File: verif/scmr_loader.sv */
// loader model: drives memory clock, chip enable and reset/oe pins
module scmr_loader
(
   input  wire logic CLK_SYS,
   output logic      CLK_IN,
   output logic      CE_N,
   output logic      RESET_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      CLK_IN = 1'b0;
      CE_N = 1'b1;
      RESET_OE = 1'b0;
   end
   task set_pins(input logic ce_n, input logic roe);
      @(posedge CLK_SYS);
      CE_N <= ce_n;
      RESET_OE <= roe;
   endtask
   // clock stands low between pulses
   task pulse(input int len);
      @(posedge CLK_SYS);
      CLK_IN <= 1'b1;
      repeat (len) @(posedge CLK_SYS);
      CLK_IN <= 1'b0;
      repeat (len) @(posedge CLK_SYS);
   endtask
endmodule

/* File: verif/test_scmr_reader.sv */
// self-checking bench for the serial configuration memory reader
module test_scmr_reader import scmr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------
   // setup
   // ---------------------------------------------
   localparam logic [SCMR_ADDR_W-1:0] LAST = 22'h00_000F;
   localparam logic [15:0] IMG = 16'h3CA5;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        sel = 1'b1;
   logic        pol = 1'b0;
   logic        we = 1'b0;
   logic [18:0] la = 19'h0_0000;
   logic [7:0]  ld = 8'h00;
   logic        cin, ce_n, roe, dout, doe, stby, pmode;
   logic [21:0] addr;
   int          failures = 0;
   int          total_checks = 0;
   always #5 clk = ~clk;
   scmr_loader ld_u (.CLK_SYS(clk), .CLK_IN(cin), .CE_N(ce_n),
      .RESET_OE(roe));
   scmr_reader #(.LAST_ADDR(LAST)) dut_u (.CLK_SYS(clk), .RESETN(rstn),
      .CLK_IN(cin), .CE_N(ce_n), .RESET_OE(roe),
      .SERIAL_PROGRAM_SELECT(sel), .RESET_POLARITY_HIGH(pol),
      .DATA_IN(1'b0), .LOAD_WE(we), .LOAD_ADDR(la), .LOAD_DATA(ld),
      .DATA_OUT(dout), .DATA_OE(doe), .STANDBY(stby),
      .PROGRAM_MODE(pmode), .ADDRESS(addr));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task chk_a(input string w, input logic [21:0] e, input logic [21:0] g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask
   task chk_b(input string w, input logic e, input logic g);
      chk_a(w, {21'h00_0000, e}, {21'h00_0000, g});
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task end_sim;
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_program;
      sel <= 1'b0;
      wt(4);
      chk_b("program mode", 1'b1, pmode);
      for (int b = 0; b < 2; b++)
      begin
         we <= 1'b1;
         la <= 19'(b);
         ld <= IMG[b*8 +: 8];
         wt(1);
      end
      we <= 1'b0;
      ld_u.set_pins(1'b1, 1'b1);
      wt(4);
      chk_b("standby in program", 1'b0, stby);
      ld_u.set_pins(1'b1, 1'b0);
      sel <= 1'b1;
      wt(4);
      chk_b("read mode", 1'b0, pmode);
      chk_b("oe in reset", 1'b0, doe);
      chk_a("address in reset", 22'h00_0000, addr);
   endtask
   task t_read;
      ld_u.set_pins(1'b0, 1'b1);
      wt(4);
      chk_b("oe", 1'b1, doe);
      chk_b("bit 0", IMG[0], dout);
      for (int k = 1; k <= 17; k++)
      begin
         ld_u.pulse(k % 2 ? 3 : 6);
         wt(2);
         chk_a("address", (k > 15) ? LAST : 22'(k), addr);
         if (k < 16)
            chk_b("data bit", IMG[k], dout);
      end
   endtask
   task t_standby;
      ld_u.set_pins(1'b0, 1'b0);
      wt(4);
      ld_u.set_pins(1'b1, 1'b1);
      wt(4);
      chk_b("standby", 1'b1, stby);
      chk_b("oe held off", 1'b0, doe);
      ld_u.pulse(3);
      wt(2);
      chk_a("halted address", 22'h00_0000, addr);
      ld_u.set_pins(1'b0, 1'b1);
      ld_u.pulse(3);
      wt(2);
      chk_a("resumed address", 22'h00_0001, addr);
      ld_u.set_pins(1'b0, 1'b0);
      wt(4);
      chk_a("address cleared", 22'h00_0000, addr);
      chk_b("oe cleared", 1'b0, doe);
   endtask
   task t_polarity;
      ld_u.set_pins(1'b0, 1'b1);
      ld_u.pulse(3);
      ld_u.pulse(3);
      wt(2);
      chk_a("address before reset", 22'h00_0002, addr);
      rstn <= 1'b0;
      pol <= 1'b1;
      wt(2);
      rstn <= 1'b1;
      wt(1);
      chk_a("power-up address", 22'h00_0000, addr);
      wt(4);
      chk_b("oe high reset", 1'b0, doe);
      ld_u.set_pins(1'b0, 1'b0);
      wt(4);
      chk_b("oe low enable", 1'b1, doe);
   endtask
   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      wt(10);
      rstn <= 1'b1;
      wt(2);
      chk_a("address after power-up", 22'h00_0000, addr);
      t_program();
      t_read();
      t_standby();
      t_polarity();
      end_sim();
   end
   initial
   begin
      #100us;
      failures++;
      end_sim();
   end
endmodule
